/* File: common/csprr_pkg.sv */
// constants and types shared by both ends of the card status register link
package csprr_pkg;
  // register indices on the link (byte offsets from the config base)
  localparam logic [2:0] CSPRR_IDX_OPTION = 3'h0;
  localparam logic [2:0] CSPRR_IDX_STATUS = 3'h1;
  localparam logic [2:0] CSPRR_IDX_PINREP = 3'h2;
  localparam logic [2:0] CSPRR_IDX_SOCKET = 3'h3;
  // card status register fields
  localparam int CSPRR_ST_CHANGED = 7;
  localparam int CSPRR_ST_CHANGE_SIGNAL_ENABLE = 6;
  localparam int CSPRR_ST_BYTEIO = 5;
  localparam int CSPRR_ST_AUDIO = 3;
  localparam int CSPRR_ST_PWRDN = 2;
  localparam int CSPRR_ST_INTR = 1;
  // host-writable bits of the card status register
  localparam logic [7:0] CSPRR_ST_WMASK = 8'h6C;
  // pin replacement layout: change bits sit above level bits
  localparam int CSPRR_PR_CHG_LSB = 4;
  localparam int CSPRR_PR_LVL_W = 4;
  // socket/copy write mask, option index mask and reset value
  localparam logic [7:0] CSPRR_SC_WMASK = 8'h7F;
  localparam logic [7:0] CSPRR_OPT_IDX_MASK = 8'h3F;
  localparam logic [7:0] CSPRR_RESET_VAL = 8'h00;
  // avalon register offsets of the host controller (word addresses)
  localparam logic [1:0] CSPRR_AV_CMD = 2'h0;
  localparam logic [1:0] CSPRR_AV_WDATA = 2'h1;
  localparam logic [1:0] CSPRR_AV_RDATA = 2'h2;
  localparam logic [1:0] CSPRR_AV_STAT = 2'h3;
  // command word fields
  localparam int CSPRR_CMD_WR = 8;
  localparam int CSPRR_CMD_IDX_LSB = 0;
  typedef enum logic [1:0] {
    CSPRR_IDLE = 2'b00,
    CSPRR_REQ = 2'b01,
    CSPRR_DONE = 2'b11
  } csprr_state_t;
endpackage

/* File: common/csprr_if.sv */
// link between host socket adapter and card register bank
`timescale 1ns/1ps
interface csprr_if;
  logic req;
  logic wr;
  logic [2:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic status_change_n;
  logic battery_detect2;
  modport card (
    input req, wr, idx, wdata,
    output rdata, ack, status_change_n, battery_detect2
  );
  modport host (
    output req, wr, idx, wdata,
    input rdata, ack, status_change_n, battery_detect2
  );
endinterface

/* File: logic/csprr_card.sv */
// card end: status, pin replacement and socket/copy registers
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - changed bit is OR of change bits
// - drive status change low when flagged
// - hold status change high when disabled
// - host steers change signal enable
// - byte-only host splits wide accesses
// - status bits 4 and 0 read zero
// - audio replaces battery detect 2 pin
// - power down request drives low-power output
// - host avoids power down while busy
// - interrupt bit follows internal request
// - low nibble masks upper writes
// - level change sets change bit
// - battery warn levels readable
// - ready level readable
// - write protect level readable
// - mask one writes change bit too
// - socket written before configuration index
// - socket number field identifies position
// - copy number written by host
// - socket register top bit zero
// - configured only for nonzero index
module csprr_card (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  csprr_if.card lnk,
  input wire logic batt_warn1_in,
  input wire logic batt_warn2_in,
  input wire logic ready_in,
  input wire logic wp_in,
  input wire logic intr_req,
  input wire logic audio_in,
  output logic power_down_request,
  output logic host_byte_only_io,
  output logic io_configured,
  output logic [3:0] socket_number,
  output logic [2:0] copy_number
);
  import csprr_pkg::*;

  logic [3:0] lvl_s1;
  logic [3:0] lvl_s2;
  logic [3:0] lvl_q;
  logic [3:0] chg;
  logic [7:0] status;
  logic [7:0] socket_and_copy;
  logic [7:0] option;
  logic [7:0] rdata;
  logic ack;
  logic [2:0] prime;
  logic [3:0] raw_lvl;
  wire [3:0] next_chg;
  logic [7:0] rd_mux;
  logic [7:0] status_rd;
  // register selects shared by the write strobes and the read mux
  wire sel_st = (lnk.idx == CSPRR_IDX_STATUS);
  wire sel_pin = (lnk.idx == CSPRR_IDX_PINREP);
  wire sel_sc = (lnk.idx == CSPRR_IDX_SOCKET);
  wire sel_opt = (lnk.idx == CSPRR_IDX_OPTION);
  wire take = lnk.req & ~ack;
  wire wr_go = take & lnk.wr;
  wire wr_pin = wr_go & sel_pin;
  wire wr_st = wr_go & sel_st;
  wire wr_sc = wr_go & sel_sc;
  wire wr_opt = wr_go & sel_opt;
  wire [3:0] wmask = lnk.wdata[CSPRR_PR_LVL_W-1:0];
  wire [3:0] wchg = lnk.wdata[CSPRR_PR_CHG_LSB +: CSPRR_PR_LVL_W];
  wire [3:0] host_wr_en = {CSPRR_PR_LVL_W{wr_pin}} & wmask;
  // compare only once both stages hold post-reset samples of the pins
  wire [3:0] edge_det = prime[2] ? (lvl_s2 ^ lvl_q) : 4'h0;
  wire changed = |chg;
  wire configured;
  wire change_signal_enable_on;
  wire audio_on;

  // ordering: bit 3 warn1, 2 warn2, 1 ready, 0 write protect
  assign raw_lvl = {batt_warn1_in, batt_warn2_in, ready_in, wp_in};

  ////////////////////////////////////////////////////////////////////
  // nonzero index configures
  assign configured = |(option & CSPRR_OPT_IDX_MASK);
  assign io_configured = configured;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lvl_s1 <= CSPRR_RESET_VAL[3:0];
      lvl_s2 <= CSPRR_RESET_VAL[3:0];
    end else if (clk_en) begin
      lvl_s1 <= raw_lvl;
      lvl_s2 <= lvl_s1;
    end
  end

  // compare stage: reads only the second sync flop, never the first
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lvl_q <= CSPRR_RESET_VAL[3:0];
    end else if (clk_en) begin
      lvl_q <= lvl_s2;
    end
  end

  // warm-up: a pin already high at reset release must not look like an edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prime <= CSPRR_RESET_VAL[2:0];
    end else if (clk_en) begin
      prime <= {prime[1:0], 1'b1};
    end
  end

  // per-bit change flag: hardware set wins over host write
  genvar i;
  generate
    for (i = 0; i < CSPRR_PR_LVL_W; i++) begin : g_chg
      // mask gates write; mask one writes change bit; edge sets
      assign next_chg[i] = edge_det[i] ? 1'b1 :
                           host_wr_en[i] ? wchg[i] : chg[i];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      chg <= CSPRR_RESET_VAL[3:0];
    end else if (clk_en) begin
      chg <= next_chg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // host-writable status bits; byte-only flag kept for card logic
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status <= CSPRR_RESET_VAL;
    end else if (clk_en & wr_st) begin
      status <= lnk.wdata & CSPRR_ST_WMASK;
    end
  end

  // top bit forced zero; socket and copy stored
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      socket_and_copy <= CSPRR_RESET_VAL;
    end else if (clk_en & wr_sc) begin
      socket_and_copy <= lnk.wdata & CSPRR_SC_WMASK;
    end
  end

  // option kept whole so a readback returns what the host wrote;
  // only its index field decides whether the card counts as configured
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      option <= CSPRR_RESET_VAL;
    end else if (clk_en & wr_opt) begin
      option <= lnk.wdata;
    end
  end

  // summary bit; reserved bits zero; live interrupt state
  always_comb begin
    status_rd = status & CSPRR_ST_WMASK;
    status_rd[CSPRR_ST_CHANGED] = changed;
    status_rd[CSPRR_ST_INTR] = intr_req;
  end

  // levels read back from synchronised inputs
  assign rd_mux = sel_st ? status_rd :
                  sel_pin ? {chg, lvl_s2} :
                  sel_sc ? socket_and_copy :
                  sel_opt ? option : CSPRR_RESET_VAL;

  // one-cycle ack per request; host drops req after seeing it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
    end else if (clk_en) begin
      ack <= take;
    end
  end

  // rdata held until the next request so a slow host can still fetch it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= CSPRR_RESET_VAL;
    end else if (clk_en & take) begin
      rdata <= rd_mux;
    end
  end

  assign lnk.ack = ack;
  assign lnk.rdata = rdata;

  ////////////////////////////////////////////////////////////////////
  // change pin low only when flagged, enabled and configured
  // combinational pin: follows a new change bit without an extra cycle
  assign change_signal_enable_on = status[CSPRR_ST_CHANGE_SIGNAL_ENABLE];
  assign lnk.status_change_n = ~(changed & change_signal_enable_on & configured);
  // audio replaces battery warn 2 on the pin
  assign audio_on = status[CSPRR_ST_AUDIO] & configured;
  assign lnk.battery_detect2 = audio_on ? audio_in : lvl_s2[2];
  // power-down request to card power logic
  assign power_down_request = status[CSPRR_ST_PWRDN];
  // byte-only access hint for overlapping wide registers
  assign host_byte_only_io = status[CSPRR_ST_BYTEIO];
  assign socket_number = socket_and_copy[3:0];
  assign copy_number = socket_and_copy[6:4];
endmodule

/* File: logic/csprr_host.sv */
// host end: avalon slave turning commands into card register cycles
`timescale 1ns/1ps
module csprr_host (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  csprr_if.host lnk,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic card_ready
);
  import csprr_pkg::*;

  csprr_state_t state;
  csprr_state_t next_state;
  logic [8:0] cmd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic refused;
  logic [31:0] rd_word;
  logic rd_hold;

  wire is_cmd = avs_write & (avs_address == CSPRR_AV_CMD);
  wire [2:0] cmd_idx = avs_writedata[CSPRR_CMD_IDX_LSB +: 3];
  wire cmd_wr = avs_writedata[CSPRR_CMD_WR];
  // refuse power-down write while card busy
  wire pd_block = cmd_wr & (cmd_idx == CSPRR_IDX_STATUS) & wdata[CSPRR_ST_PWRDN] & ~card_ready;
  wire start = is_cmd & (state == CSPRR_IDLE) & ~pd_block;
  wire busy = (state != CSPRR_IDLE);
  // command write stalls until link idle; a read waits one cycle for its data
  wire rd_wait = avs_read & ~rd_hold;
  wire ce_wait = (avs_read | avs_write) & ~clk_en;
  assign avs_waitrequest = (is_cmd & busy) | rd_wait | ce_wait;

  always_comb begin
    case (state)
      CSPRR_IDLE: next_state = start ? CSPRR_REQ : CSPRR_IDLE;
      CSPRR_REQ: next_state = lnk.ack ? CSPRR_DONE : CSPRR_REQ;
      CSPRR_DONE: next_state = CSPRR_IDLE;
      default: next_state = CSPRR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= CSPRR_IDLE;
      cmd <= 9'h000;
      wdata <= CSPRR_RESET_VAL;
      rdata <= CSPRR_RESET_VAL;
      refused <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      if (avs_write & (avs_address == CSPRR_AV_WDATA)) begin
        wdata <= avs_writedata[7:0];
      end
      if (start) begin
        cmd <= avs_writedata[8:0];
      end
      if (is_cmd & ~busy) begin
        refused <= pd_block;
      end
      if ((state == CSPRR_REQ) & lnk.ack) begin
        rdata <= lnk.rdata;
      end
    end
  end

  assign lnk.req = (state == CSPRR_REQ) & ~lnk.ack;
  assign lnk.wr = cmd[CSPRR_CMD_WR];
  assign lnk.idx = cmd[2:0];
  // reserved top bit of socket register written as zero
  assign lnk.wdata = (cmd[2:0] == CSPRR_IDX_SOCKET) ? (wdata & CSPRR_SC_WMASK) : wdata;

  assign rd_word = (avs_address == CSPRR_AV_RDATA) ? {24'h000000, rdata} :
                   (avs_address == CSPRR_AV_STAT) ?
                   {28'h0000000, lnk.battery_detect2, ~lnk.status_change_n, refused, busy} :
                   (avs_address == CSPRR_AV_WDATA) ? {24'h000000, wdata} :
                   {23'h000000, cmd};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h00000000;
    end else if (clk_en & rd_wait) begin
      avs_readdata <= rd_word;
    end
  end

  // read data is registered, so every read spends one wait cycle fetching it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_hold <= 1'b0;
    end else if (clk_en) begin
      rd_hold <= rd_wait;
    end
  end
endmodule

/* File: verification/csprr_link_sva.sv */
// link checker for the card register bank
`timescale 1ns/1ps
module csprr_link_sva (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic req,
  input wire logic wr,
  input wire logic [2:0] idx,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic status_change_n,
  input wire logic battery_detect2
);
  import csprr_pkg::*;
  logic w_q;
  logic [2:0] i_q;
  logic [7:0] d_q, cfg, st, sc;
  // request fields captured, host may drop them with ack
  wire rd_st = ack && !w_q && i_q == CSPRR_IDX_STATUS;
  wire wr_ok = ack && w_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {w_q, i_q, d_q, cfg, st, sc} <= '0;
    end else begin
      if (req && !ack) {w_q, i_q, d_q} <= {wr, idx, wdata};
      if (wr_ok && i_q == CSPRR_IDX_OPTION) cfg <= d_q & CSPRR_OPT_IDX_MASK;
      if (wr_ok && i_q == CSPRR_IDX_STATUS) st <= d_q & CSPRR_ST_WMASK;
      if (wr_ok && i_q == CSPRR_IDX_SOCKET) sc <= d_q & CSPRR_SC_WMASK;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  chk_ack_after_req: assert property (req && !ack |=> ack)
    else $error("ack missing after request");
  chk_ack_one_cycle: assert property (ack |=> !ack ##1 !ack)
    else $error("ack longer than one cycle");
  chk_status_reserved: assert property (rd_st |-> rdata[4] == 1'b0 && rdata[0] == 1'b0)
    else $error("reserved status bits set");
  chk_status_readback: assert property (rd_st |-> (rdata & CSPRR_ST_WMASK) == st)
    else $error("status host bits differ");
  chk_socket_readback: assert property (ack && !w_q && i_q == CSPRR_IDX_SOCKET |-> rdata == sc)
    else $error("socket register readback wrong");
  chk_change_pulls_low: assert property (rd_st && rdata[7] && rdata[6] && cfg != 0 |-> !status_change_n)
    else $error("status change pin not low");
  chk_sig_off_high: assert property (!ack && cfg != 0 && !st[CSPRR_ST_CHANGE_SIGNAL_ENABLE] |-> status_change_n)
    else $error("status change pin low while disabled");
  chk_unconfig_high: assert property (!ack && cfg == 0 |-> status_change_n)
    else $error("status change pin low while unconfigured");
endmodule

/* File: verification/testbench.sv */
// self-checking bench: avalon host controller driving the card over the link
`timescale 1ns/1ps
module testbench;
  import csprr_pkg::*;
  logic sys_clk, resetn, rd, wr, intr, aud, rdy, pd, b8, cfgd;
  logic [1:0] adr;
  logic [31:0] wd, rdat, got;
  logic [3:0] lvl, sock;
  logic [2:0] copy;
  logic [7:0] v;
  logic wreq, ce;
  int num_errors = 0;
  int tests_run = 0;
  csprr_if lnk ();
  csprr_card u_csprr_card (.sys_clk(sys_clk), .resetn(resetn), .clk_en(ce), .lnk(lnk.card),
    .batt_warn1_in(lvl[3]), .batt_warn2_in(lvl[2]), .ready_in(lvl[1]), .wp_in(lvl[0]),
    .intr_req(intr), .audio_in(aud), .power_down_request(pd), .host_byte_only_io(b8),
    .io_configured(cfgd), .socket_number(sock), .copy_number(copy));
  csprr_host u_csprr_host (.sys_clk(sys_clk), .resetn(resetn), .clk_en(ce), .lnk(lnk.host),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .card_ready(rdy));
  csprr_link_sva u_csprr_link_sva (.sys_clk(sys_clk), .resetn(resetn), .req(lnk.req),
    .wr(lnk.wr), .idx(lnk.idx), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack),
    .status_change_n(lnk.status_change_n), .battery_detect2(lnk.battery_detect2));
  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // one avalon cycle: request held until waitrequest is sampled low at an edge
  task automatic av(input logic r, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    adr <= a;
    wd <= d;
    rd <= r;
    wr <= !r;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wreq && n < 99);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq) chk(32'h0, 32'h1);
    if (wreq) stop_test();
  endtask
  task automatic reg_op(input logic w, input logic [2:0] i, input logic [7:0] d);
    int n;
    n = 0;
    if (w) av(1'b0, CSPRR_AV_WDATA, {24'h0, d});
    av(1'b0, CSPRR_AV_CMD, {23'h0, w, 5'h0, i});
    do begin
      av(1'b1, CSPRR_AV_STAT, 32'h0);
      n++;
    end while (got[0] && n < 50);
    if (got[0]) chk(32'h0, 32'h1);
    if (got[0]) stop_test();
    if (!w) av(1'b1, CSPRR_AV_RDATA, 32'h0);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    {resetn, rd, wr, intr, aud, adr, wd, lvl} = '0;
    rdy = 1'b1;
    ce = 1'b1;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reg_op(1'b0, CSPRR_IDX_STATUS, 8'h00);
    chk(got, 32'h0);
    reg_op(1'b1, CSPRR_IDX_SOCKET, 8'hB5);
    reg_op(1'b1, CSPRR_IDX_OPTION, 8'h01);
    chk(cfgd, 1'b1);
    reg_op(1'b1, CSPRR_IDX_STATUS, 8'hFF);
    @(posedge sys_clk) intr <= 1'b1;
    reg_op(1'b0, CSPRR_IDX_STATUS, 8'h00);
    chk(got, 32'h6E);
    chk({pd, b8}, 2'b11);
    @(posedge sys_clk) aud <= 1'b1;
    @(negedge sys_clk);
    chk(lnk.battery_detect2, 1'b1);
    // each level input in turn: set change, inhibited write, masked clear
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) lvl[i] <= 1'b1;
      repeat (5) @(negedge sys_clk);
      chk(lnk.status_change_n, 1'b0);
      v = {4'(1 << i), 4'((2 << i) - 1)};
      reg_op(1'b0, CSPRR_IDX_PINREP, 8'h00);
      chk(got, v);
      reg_op(1'b0, CSPRR_IDX_STATUS, 8'h00);
      chk(got[7], 1'b1);
      reg_op(1'b1, CSPRR_IDX_PINREP, 8'hF0);
      reg_op(1'b0, CSPRR_IDX_PINREP, 8'h00);
      chk(got, v);
      reg_op(1'b1, CSPRR_IDX_PINREP, {4'h0, 4'(1 << i)});
      reg_op(1'b0, CSPRR_IDX_PINREP, 8'h00);
      chk(got, {4'h0, v[3:0]});
    end
    @(posedge sys_clk) aud <= 1'b0;
    @(negedge sys_clk);
    chk(lnk.battery_detect2, 1'b0);
    reg_op(1'b1, CSPRR_IDX_STATUS, 8'h00);
    @(posedge sys_clk) lvl[0] <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(lnk.status_change_n, 1'b1);
    // frozen card must not see a pin pulse that is gone before it wakes
    @(posedge sys_clk) ce <= 1'b0;
    lvl[1] <= 1'b0;
    repeat (6) @(posedge sys_clk);
    lvl[1] <= 1'b1;
    @(posedge sys_clk) ce <= 1'b1;
    reg_op(1'b0, CSPRR_IDX_PINREP, 8'h00);
    chk(got, 32'h1E);
    @(posedge sys_clk) rdy <= 1'b0;
    reg_op(1'b1, CSPRR_IDX_STATUS, 8'h04);
    chk(got[1], 1'b1);
    chk(pd, 1'b0);
    reg_op(1'b0, CSPRR_IDX_SOCKET, 8'h00);
    chk(got, 32'h35);
    chk({copy, sock}, 7'h35);
    stop_test();
  end
endmodule
